//--- sdcd_consts.vh
// constants for the command dispatch and software reset block
`ifndef SDCD_CONSTS_VH
`define SDCD_CONSTS_VH

// frame type codes
`define SDCD_FIS_REG_H2D 8'h27
`define SDCD_FIS_REG_D2H 8'h34
`define SDCD_FIS_DMA_SETUP 8'h41
`define SDCD_FIS_SDB 8'hA1

// register byte offsets
`define SDCD_OFF_CTRL 12'h000
`define SDCD_OFF_DEVREG 12'h004
`define SDCD_OFF_SERVICE 12'h008
`define SDCD_OFF_REPLY 12'h00C
`define SDCD_OFF_STATE 12'h010
`define SDCD_OFF_COUNT 12'h014
`define SDCD_OFF_CLASS_BASE 12'h400

// reset values
`define SDCD_RST_CTRL 1'h0
`define SDCD_RST_DEV_STATUS 8'h50
`define SDCD_RST_DEV_ERROR 8'h00
`define SDCD_RST_ABORT_ERROR 8'h04
`define SDCD_RST_ABORT_STATUS 8'h51

// status and reply field values
`define SDCD_STAT_SERV 8'h10
`define SDCD_STAT_BSY 8'h80
`define SDCD_STAT_DRQ 8'h08
`define SDCD_DIAG_STATUS 8'h50
`define SDCD_DIAG_ERR_GOOD 8'h01
`define SDCD_DIAG_ERR_BAD 8'h02
`define SDCD_SIG_COUNT 8'h01
`define SDCD_SIG_SECTOR 8'h01
`define SDCD_SIG_PKT_LOW 8'h14
`define SDCD_SIG_PKT_HIGH 8'hEB

// command class codes held in the class table; also the handler select codes
`define SDCD_CLS_NONE 5'h00
`define SDCD_CLS_NONDATA 5'h01
`define SDCD_CLS_PIO_IN 5'h02
`define SDCD_CLS_PIO_OUT 5'h03
`define SDCD_CLS_DMA_IN 5'h04
`define SDCD_CLS_DMA_OUT 5'h05
`define SDCD_CLS_PACKET 5'h06
`define SDCD_CLS_QDMA_IN 5'h07
`define SDCD_CLS_QDMA_OUT 5'h08
`define SDCD_CLS_DIAG 5'h09
`define SDCD_CLS_DEVRESET 5'h0A
`define SDCD_CLS_SERVICE 5'h0B
`define SDCD_SEL_PKT_PIO_IN 5'h0C
`define SDCD_SEL_PKT_PIO_OUT 5'h0D
`define SDCD_SEL_PKT_DMA_IN 5'h0E
`define SDCD_SEL_PKT_DMA_OUT 5'h0F
`define SDCD_SEL_Q_SEND_DATA 5'h10
`define SDCD_SEL_Q_SEND_ACT 5'h11

// pending service type codes
`define SDCD_SVC_PIO_IN 3'h0
`define SDCD_SVC_PIO_OUT 3'h1
`define SDCD_SVC_DMA_IN 3'h2
`define SDCD_SVC_DMA_OUT 3'h3
`define SDCD_SVC_QDMA_IN 3'h4
`define SDCD_SVC_QDMA_OUT 3'h5

`define SDCD_RESP_OKAY 2'h0
`define SDCD_RESP_SLVERR 2'h2

`endif

//--- sdcd_dispatch.v
// command dispatch, service and software reset state machine with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_consts.vh"

// Operation
// RULE_01: other frame types return to idle wait
// RULE_02: classify command of new register frame
// RULE_03: non-data command goes to its handler
// RULE_04: PIO in/out commands to PIO handlers
// RULE_05: READ/WRITE DMA to DMA handlers
// RULE_06: PACKET command to packet handler
// RULE_07: queued DMA commands to queued handlers
// RULE_08: diagnostic command to diagnostic handler
// RULE_09: DEVICE RESET to device reset handler
// RULE_10: unimplemented command to unsupported reply
// RULE_11: unsupported reply sends error frame, I set
// RULE_12: SERVICE command goes to service test
// RULE_13: service notify sends SDB with SERV
// RULE_14: PIO service skips tag reply
// RULE_15: tag reply frame then service branch
// RULE_16: service branch to packet data states
// RULE_17: service branch to queued DMA states
// RULE_18: SRST frame starts reset in any mode; the code drops one that arrives in the frame check state
// RULE_19: reset asserted starts diagnostics, awaits clear
// RULE_20: C and SRST clear go to diagnostics
// RULE_21: C or SRST set stays in reset
// RULE_22: diagnostic state runs diagnostics to completion
// RULE_23: idle register frame decoded by C, SRST
// RULE_24: diagnostic result selects good or bad reply
// RULE_25: queued ready in idle enters service notify
// RULE_26: frame request held until transmitted
// RULE_27: class table decides implemented commands
module sdcd_dispatch (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite slave
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// received frame from transport layer
	input wire rx_fis_valid,
	input wire [7:0] rx_fis_type,
	input wire rx_c_bit,
	input wire rx_srst,
	input wire [7:0] rx_command,
	output reg dma_setup_seen,
	// frame transmit request to transport layer
	output reg tx_req,
	output reg [7:0] tx_fis_type,
	output reg tx_ibit,
	output reg [7:0] tx_status,
	output reg [7:0] tx_error,
	output reg [7:0] tx_sector_count,
	output reg [7:0] tx_sector_number,
	output reg [7:0] tx_cyl_low,
	output reg [7:0] tx_cyl_high,
	input wire tx_done,
	// protocol handlers
	output reg handler_start,
	output reg [4:0] handler_sel,
	input wire handler_done,
	// queued command engine and diagnostics
	input wire queued_ready,
	output reg diag_start,
	input wire diag_done,
	input wire diag_pass,
	output reg [3:0] state_out
);

	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_FCHECK = 4'h1;
	localparam [3:0] ST_CLASSIFY = 4'h2;
	localparam [3:0] ST_UNSUP = 4'h3;
	localparam [3:0] ST_SNOTIFY = 4'h4;
	localparam [3:0] ST_STEST = 4'h5;
	localparam [3:0] ST_STAG = 4'h6;
	localparam [3:0] ST_SBRANCH = 4'h7;
	localparam [3:0] ST_RST = 4'h8;
	localparam [3:0] ST_DIAG = 4'h9;
	localparam [3:0] ST_GOOD = 4'hA;
	localparam [3:0] ST_BAD = 4'hB;
	localparam [3:0] ST_HANDLER = 4'hC;

	integer i;

	reg [3:0] state_reg;
	reg [7:0] fr_type_reg;
	reg fr_c_reg;
	reg fr_srst_reg;
	reg [7:0] fr_cmd_reg;
	reg diag_seen_reg;
	reg diag_pass_reg;
	reg [15:0] unsup_count_reg;

	// software registers
	reg ctrl_packet_reg;
	reg [7:0] dev_status_reg;
	reg [7:0] dev_error_reg;
	reg [4:0] svc_tag_reg;
	reg [2:0] svc_type_reg;
	reg [7:0] abort_error_reg;
	reg [7:0] abort_status_reg;
	reg [4:0] class_mem [0:255];

	reg [11:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;

	wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_class = (awaddr_reg[11:10] == 2'h1);
	wire rd_class = (s_axi_araddr[11:10] == 2'h1);
	wire [4:0] cmd_class = class_mem[fr_cmd_reg];
	wire srst_frame = rx_fis_valid && (rx_fis_type == `SDCD_FIS_REG_H2D) && !rx_c_bit && rx_srst;
	wire svc_is_pio = (svc_type_reg == `SDCD_SVC_PIO_IN) || (svc_type_reg == `SDCD_SVC_PIO_OUT);

	// write channel: address and data taken in either order, one response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SDCD_RESP_OKAY;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				if (wr_class || awaddr_reg == `SDCD_OFF_CTRL || awaddr_reg == `SDCD_OFF_DEVREG ||
					awaddr_reg == `SDCD_OFF_SERVICE || awaddr_reg == `SDCD_OFF_REPLY) begin
					s_axi_bresp <= `SDCD_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SDCD_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register writes; the class table resets to all unimplemented until software loads it
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_packet_reg <= `SDCD_RST_CTRL;
			dev_status_reg <= `SDCD_RST_DEV_STATUS;
			dev_error_reg <= `SDCD_RST_DEV_ERROR;
			svc_tag_reg <= 5'h00;
			svc_type_reg <= 3'h0;
			abort_error_reg <= `SDCD_RST_ABORT_ERROR;
			abort_status_reg <= `SDCD_RST_ABORT_STATUS;
			for (i = 0; i < 256; i = i + 1) begin
				class_mem[i] <= `SDCD_CLS_NONE;
			end
		end else if (wr_fire) begin
			// RULE_27 table load
			if (wr_class && wstrb_reg[0]) begin
				class_mem[awaddr_reg[9:2]] <= wdata_reg[4:0];
			end
			if (awaddr_reg == `SDCD_OFF_CTRL && wstrb_reg[0]) begin
				ctrl_packet_reg <= wdata_reg[0];
			end
			if (awaddr_reg == `SDCD_OFF_DEVREG) begin
				if (wstrb_reg[0]) begin
					dev_status_reg <= wdata_reg[7:0];
				end
				if (wstrb_reg[1]) begin
					dev_error_reg <= wdata_reg[15:8];
				end
			end
			if (awaddr_reg == `SDCD_OFF_SERVICE) begin
				if (wstrb_reg[0]) begin
					svc_tag_reg <= wdata_reg[4:0];
				end
				if (wstrb_reg[1]) begin
					svc_type_reg <= wdata_reg[10:8];
				end
			end
			if (awaddr_reg == `SDCD_OFF_REPLY) begin
				if (wstrb_reg[0]) begin
					abort_error_reg <= wdata_reg[7:0];
				end
				if (wstrb_reg[1]) begin
					abort_status_reg <= wdata_reg[15:8];
				end
			end
		end
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SDCD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SDCD_RESP_OKAY;
			if (rd_class) begin
				s_axi_rdata <= {27'h0000000, class_mem[s_axi_araddr[9:2]]};
			end else begin
				case (s_axi_araddr)
					`SDCD_OFF_CTRL: s_axi_rdata <= {31'h00000000, ctrl_packet_reg};
					`SDCD_OFF_DEVREG: s_axi_rdata <= {16'h0000, dev_error_reg, dev_status_reg};
					`SDCD_OFF_SERVICE: s_axi_rdata <= {21'h000000, svc_type_reg, 3'h0, svc_tag_reg};
					`SDCD_OFF_REPLY: s_axi_rdata <= {16'h0000, abort_status_reg, abort_error_reg};
					`SDCD_OFF_STATE: s_axi_rdata <= {14'h0000, diag_pass_reg, diag_seen_reg,
						fr_cmd_reg, 4'h0, state_reg};
					`SDCD_OFF_COUNT: s_axi_rdata <= {16'h0000, unsup_count_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `SDCD_RESP_SLVERR;
					end
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// diagnostics result latch; a done in the clearing cycle still counts
	always @(posedge aclk) begin
		if (!aresetn) begin
			diag_seen_reg <= 1'b0;
			diag_pass_reg <= 1'b0;
		end else if (diag_done) begin
			diag_seen_reg <= 1'b1;
			diag_pass_reg <= diag_pass;
		end else if (diag_start) begin
			diag_seen_reg <= 1'b0;
		end
	end

	// main state machine
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			fr_type_reg <= 8'h00;
			fr_c_reg <= 1'b0;
			fr_srst_reg <= 1'b0;
			fr_cmd_reg <= 8'h00;
			unsup_count_reg <= 16'h0000;
			dma_setup_seen <= 1'b0;
			tx_req <= 1'b0;
			tx_fis_type <= 8'h00;
			tx_ibit <= 1'b0;
			tx_status <= 8'h00;
			tx_error <= 8'h00;
			tx_sector_count <= 8'h00;
			tx_sector_number <= 8'h00;
			tx_cyl_low <= 8'h00;
			tx_cyl_high <= 8'h00;
			handler_start <= 1'b0;
			handler_sel <= `SDCD_CLS_NONE;
			diag_start <= 1'b0;
		end else begin
			dma_setup_seen <= 1'b0;
			handler_start <= 1'b0;
			diag_start <= 1'b0;
			// RULE_26 drop request once sent
			if (tx_req && tx_done) begin
				tx_req <= 1'b0;
			end
			case (state_reg)
				ST_IDLE: begin
					if (rx_fis_valid) begin
						fr_type_reg <= rx_fis_type;
						fr_c_reg <= rx_c_bit;
						fr_srst_reg <= rx_srst;
						fr_cmd_reg <= rx_command;
						state_reg <= ST_FCHECK;
					// RULE_25 queued data ready
					end else if (queued_ready) begin
						state_reg <= ST_SNOTIFY;
					end
				end
				ST_FCHECK: begin
					if (fr_type_reg == `SDCD_FIS_REG_H2D) begin
						// RULE_23 decode C and SRST
						if (fr_c_reg) begin
							state_reg <= ST_CLASSIFY;
						end else if (fr_srst_reg) begin
							diag_start <= 1'b1;
							state_reg <= ST_RST;
						end else begin
							state_reg <= ST_IDLE;
						end
					end else begin
						// RULE_01 other frames dropped
						dma_setup_seen <= (fr_type_reg == `SDCD_FIS_DMA_SETUP);
						state_reg <= ST_IDLE;
					end
				end
				ST_CLASSIFY: begin
					// RULE_02 RULE_27 classify by table
					case (cmd_class)
						// RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08 RULE_09 start handler
						`SDCD_CLS_NONDATA, `SDCD_CLS_PIO_IN, `SDCD_CLS_PIO_OUT, `SDCD_CLS_DMA_IN,
						`SDCD_CLS_DMA_OUT, `SDCD_CLS_PACKET, `SDCD_CLS_QDMA_IN, `SDCD_CLS_QDMA_OUT,
						`SDCD_CLS_DIAG, `SDCD_CLS_DEVRESET: begin
							handler_start <= 1'b1;
							handler_sel <= cmd_class;
							state_reg <= ST_HANDLER;
						end
						// RULE_12 service command
						`SDCD_CLS_SERVICE: state_reg <= ST_STEST;
						// RULE_10 unimplemented opcode
						default: begin
							unsup_count_reg <= unsup_count_reg + 16'h0001;
							state_reg <= ST_UNSUP;
						end
					endcase
				end
				ST_UNSUP: begin
					// RULE_11 error reply with I set
					if (!tx_req) begin
						tx_req <= 1'b1;
						tx_fis_type <= `SDCD_FIS_REG_D2H;
						tx_ibit <= 1'b1;
						tx_status <= abort_status_reg;
						tx_error <= abort_error_reg;
						tx_sector_count <= 8'h00;
						tx_sector_number <= 8'h00;
						tx_cyl_low <= 8'h00;
						tx_cyl_high <= 8'h00;
					end else if (tx_done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_SNOTIFY: begin
					// RULE_13 SDB with SERV, other bits copied
					if (!tx_req) begin
						tx_req <= 1'b1;
						tx_fis_type <= `SDCD_FIS_SDB;
						tx_ibit <= 1'b1;
						tx_status <= dev_status_reg | `SDCD_STAT_SERV;
						tx_error <= dev_error_reg;
						tx_sector_count <= 8'h00;
						tx_sector_number <= 8'h00;
						tx_cyl_low <= 8'h00;
						tx_cyl_high <= 8'h00;
					end else if (tx_done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_STEST: begin
					// RULE_14 PIO provides its own tag update
					state_reg <= svc_is_pio ? ST_SBRANCH : ST_STAG;
				end
				ST_STAG: begin
					// RULE_15 tag reply, BSY clear and DRQ set
					if (!tx_req) begin
						tx_req <= 1'b1;
						tx_fis_type <= `SDCD_FIS_REG_D2H;
						tx_ibit <= 1'b0;
						tx_status <= (dev_status_reg & ~`SDCD_STAT_BSY) | `SDCD_STAT_DRQ;
						tx_error <= dev_error_reg;
						tx_sector_count <= {svc_tag_reg, 3'h0};
						tx_sector_number <= 8'h00;
						tx_cyl_low <= 8'h00;
						tx_cyl_high <= 8'h00;
					end else if (tx_done) begin
						state_reg <= ST_SBRANCH;
					end
				end
				ST_SBRANCH: begin
					handler_start <= 1'b1;
					state_reg <= ST_HANDLER;
					case (svc_type_reg)
						// RULE_16 packet data states
						`SDCD_SVC_PIO_IN: handler_sel <= `SDCD_SEL_PKT_PIO_IN;
						`SDCD_SVC_PIO_OUT: handler_sel <= `SDCD_SEL_PKT_PIO_OUT;
						`SDCD_SVC_DMA_IN: handler_sel <= `SDCD_SEL_PKT_DMA_IN;
						`SDCD_SVC_DMA_OUT: handler_sel <= `SDCD_SEL_PKT_DMA_OUT;
						// RULE_17 queued DMA continuation
						`SDCD_SVC_QDMA_IN: handler_sel <= `SDCD_SEL_Q_SEND_DATA;
						`SDCD_SVC_QDMA_OUT: handler_sel <= `SDCD_SEL_Q_SEND_ACT;
						default: begin
							handler_start <= 1'b0;
							state_reg <= ST_IDLE;
						end
					endcase
				end
				ST_RST: begin
					// RULE_19 RULE_20 RULE_21 wait for SRST clear with C clear
					if (rx_fis_valid && rx_fis_type == `SDCD_FIS_REG_H2D && !rx_c_bit && !rx_srst) begin
						state_reg <= ST_DIAG;
					end
				end
				ST_DIAG: begin
					// RULE_22 RULE_24 wait for diagnostics, pick reply
					if (diag_seen_reg) begin
						state_reg <= diag_pass_reg ? ST_GOOD : ST_BAD;
					end
				end
				ST_GOOD, ST_BAD: begin
					// RULE_26 hold request until sent
					if (!tx_req) begin
						tx_req <= 1'b1;
						tx_fis_type <= `SDCD_FIS_REG_D2H;
						tx_ibit <= 1'b0;
						tx_status <= ctrl_packet_reg ? 8'h00 : `SDCD_DIAG_STATUS;
						tx_error <= (state_reg == ST_GOOD) ? `SDCD_DIAG_ERR_GOOD : `SDCD_DIAG_ERR_BAD;
						tx_sector_count <= `SDCD_SIG_COUNT;
						tx_sector_number <= `SDCD_SIG_SECTOR;
						tx_cyl_low <= ctrl_packet_reg ? `SDCD_SIG_PKT_LOW : 8'h00;
						tx_cyl_high <= ctrl_packet_reg ? `SDCD_SIG_PKT_HIGH : 8'h00;
					end else if (tx_done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_HANDLER: begin
					if (handler_done) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			// RULE_18 SRST frame aborts any state but idle, frame check and reset; idle goes through frame check
			if (srst_frame && state_reg != ST_IDLE && state_reg != ST_FCHECK && state_reg != ST_RST) begin
				tx_req <= 1'b0;
				handler_start <= 1'b0;
				diag_start <= 1'b1;
				state_reg <= ST_RST;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_out <= ST_IDLE;
		end else begin
			state_out <= state_reg;
		end
	end

endmodule // sdcd_dispatch

`default_nettype wire

//--- sdcd_dispatch_props.sv
// assertion checker for the command dispatch block
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_consts.vh"
module sdcd_dispatch_props (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// receive side
	input wire rx_fis_valid,
	input wire [7:0] rx_fis_type,
	input wire rx_c_bit,
	input wire rx_srst,
	input wire queued_ready,
	input wire dma_setup_seen,
	// transmit side
	input wire tx_req,
	input wire tx_done,
	input wire [7:0] tx_fis_type,
	input wire tx_ibit,
	input wire [7:0] tx_status,
	// handlers and state
	input wire handler_start,
	input wire [4:0] handler_sel,
	input wire diag_start,
	input wire [3:0] state_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// state_out lags one cycle, so idle frames are only judged from a settled idle
	wire idle_rx = rx_fis_valid && state_out == 4'h0;
	wire reg_rx = rx_fis_type == `SDCD_FIS_REG_H2D;
	other_frame_a: assert property (
		idle_rx && !reg_rx && rx_fis_type != `SDCD_FIS_DMA_SETUP
		|=> (!handler_start && !tx_req && !diag_start && !dma_setup_seen) [*4]) else $error("foreign frame acted on");
	dma_setup_a: assert property (
		idle_rx && rx_fis_type == `SDCD_FIS_DMA_SETUP |-> ##[1:3] dma_setup_seen) else $error("setup frame not reported");
	srst_entry_a: assert property (
		idle_rx && reg_rx && !rx_c_bit && rx_srst |-> ##[1:3] diag_start) else $error("soft reset not entered");
	quiet_frame_a: assert property (
		idle_rx && reg_rx && !rx_c_bit && !rx_srst
		|=> (!handler_start && !diag_start && !tx_req) [*4]) else $error("control frame acted on");
	handler_code_a: assert property (
		handler_start |-> handler_sel != 5'h00 && handler_sel != `SDCD_CLS_SERVICE
		&& handler_sel <= `SDCD_SEL_Q_SEND_ACT) else $error("bad handler select");
	tx_hold_a: assert property (
		tx_req && !tx_done && !rx_fis_valid
		|=> tx_req && $stable(tx_fis_type) && $stable(tx_status) && $stable(tx_ibit)) else $error("request dropped early");
	tx_release_a: assert property (
		tx_req && tx_done |=> !tx_req) else $error("request held after send");
	notify_a: assert property (
		state_out == 4'h0 && queued_ready && !rx_fis_valid && !tx_req
		|-> ##[1:4] (tx_req && tx_fis_type == `SDCD_FIS_SDB)) else $error("no service notify");
	sdb_serv_a: assert property (
		tx_req && tx_fis_type == `SDCD_FIS_SDB |-> tx_ibit && tx_status[4]) else $error("notify bits wrong");
	reset_stay_a: assert property (
		state_out == 4'h8 && rx_fis_valid && reg_rx && (rx_c_bit || rx_srst)
		|=> (!handler_start && !tx_req) [*4]) else $error("left soft reset");
	start_c: cover property (handler_start);
	notify_c: cover property (tx_req && tx_done && tx_fis_type == `SDCD_FIS_SDB);
	diag_c: cover property (diag_start);
endmodule // sdcd_dispatch_props
bind sdcd_dispatch sdcd_dispatch_props sdcd_dispatch_props_i (.aclk(aclk), .aresetn(aresetn),
	.rx_fis_valid(rx_fis_valid), .rx_fis_type(rx_fis_type), .rx_c_bit(rx_c_bit), .rx_srst(rx_srst),
	.queued_ready(queued_ready), .dma_setup_seen(dma_setup_seen), .tx_req(tx_req), .tx_done(tx_done),
	.tx_fis_type(tx_fis_type), .tx_ibit(tx_ibit), .tx_status(tx_status), .handler_start(handler_start),
	.handler_sel(handler_sel), .diag_start(diag_start), .state_out(state_out));
`default_nettype wire

//--- sdcd_host_model.sv
// transport side model answering frame transmit requests
`timescale 1ns/1ps
`default_nettype none
module sdcd_host_model (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// transmit handshake
	input wire tx_req,
	input wire slow,
	output var logic tx_done
);
	logic [2:0] wait_reg;
	// done only answers a request that is still held
	always @(posedge aclk) begin
		if (!aresetn || !tx_req || tx_done) begin
			tx_done <= 1'b0;
			wait_reg <= 3'h0;
		end else if (wait_reg >= (slow ? 3'h4 : 3'h0)) begin
			tx_done <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 3'h1;
		end
	end
endmodule // sdcd_host_model
`default_nettype wire

//--- sdcd_dispatch_tb.sv
// self-checking testbench for the command dispatch block
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_consts.vh"
module sdcd_dispatch_tb;
	reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [11:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, rnd;
	reg [3:0] s_axi_wstrb;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	reg rx_fis_valid, rx_c_bit, rx_srst, handler_done, queued_ready, diag_done, diag_pass, slow;
	reg [7:0] rx_fis_type, rx_command, op, st, er;
	reg [4:0] tg;
	reg [2:0] hcnt, dcnt;
	wire dma_setup_seen, tx_req, tx_ibit, tx_done, handler_start, diag_start;
	wire [7:0] tx_fis_type, tx_status, tx_error, tx_sector_count, tx_sector_number, tx_cyl_low, tx_cyl_high;
	wire [4:0] handler_sel;
	wire [3:0] state_out;
	logic [63:0] exp_q[$], msk_q[$];
	integer failures = 0, checks_done = 0, c;
	localparam [63:0] all_m = {64{1'b1}};
	localparam [63:0] hdr_m = 64'hFFFFFFFF00000000;
	sdcd_dispatch sdcd_dispatch_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx_fis_valid, .rx_fis_type, .rx_c_bit, .rx_srst, .rx_command, .dma_setup_seen,
		.tx_req, .tx_fis_type, .tx_ibit, .tx_status, .tx_error, .tx_sector_count, .tx_sector_number,
		.tx_cyl_low, .tx_cyl_high, .tx_done, .handler_start, .handler_sel, .handler_done, .queued_ready,
		.diag_start, .diag_done, .diag_pass, .state_out);
	sdcd_host_model sdcd_host_model_i (.aclk, .aresetn, .tx_req, .slow, .tx_done);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	function [31:0] xs(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task conclude;
		begin
			$display("checks_done=%0d failures=%0d", checks_done, failures);
			if (failures == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task lost;
		begin
			failures = failures + 1;
			$display("unexpected at %0t got %h exp %h", $time, state_out, 4'h0);
			conclude;
		end
	endtask
	task note(input [63:0] v, input [63:0] m);
		begin
			exp_q.push_back(v);
			msk_q.push_back(m);
		end
	endtask
	task take(input [63:0] v);
		reg [63:0] e, m;
		begin
			checks_done = checks_done + 1;
			e = 64'h0;
			m = all_m;
			if (exp_q.size() != 0) begin
				e = exp_q.pop_front();
				m = msk_q.pop_front();
			end
			if ((v & m) !== (e & m)) begin
				failures = failures + 1;
				$display("unexpected at %0t got %h exp %h", $time, v, e);
			end
		end
	endtask
	// results are matched in the order they leave the block
	always @(posedge aclk) begin
		// counters start clean so no unknown done pulse reaches the block
		if (!aresetn) begin
			{hcnt, dcnt, handler_done, diag_done} <= 8'h00;
		end else begin
			hcnt <= handler_start ? 3'h3 : (hcnt != 3'h0 ? hcnt - 3'h1 : 3'h0);
			handler_done <= hcnt == 3'h1;
			dcnt <= diag_start ? 3'h3 : (dcnt != 3'h0 ? dcnt - 3'h1 : 3'h0);
			diag_done <= dcnt == 3'h1;
			if (handler_start) take({4'h1, 55'h0, handler_sel});
			if (tx_req && tx_done) take({4'h3, tx_fis_type, 3'h0, tx_ibit, tx_status, tx_error,
				tx_sector_count, tx_sector_number, tx_cyl_high, tx_cyl_low});
			if (s_axi_rvalid && s_axi_rready) take({4'h2, 26'h0, s_axi_rresp, s_axi_rdata});
			if (s_axi_bvalid && s_axi_bready) take({4'h4, 58'h0, s_axi_bresp});
			if (dma_setup_seen) take(64'h5);
			if (diag_start) take(64'h6);
		end
	end
	task axw(input [11:0] a, input [31:0] d, input [1:0] r);
		integer n;
		begin
			@(posedge aclk);
			note({4'h4, 58'h0, r}, all_m);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid) begin
					s_axi_bready <= 1'b0;
					n = 99;
				end
			end
			if (n < 99) lost;
		end
	endtask
	task axr(input [11:0] a, input [31:0] d, input [1:0] r);
		integer n;
		begin
			@(posedge aclk);
			note({4'h2, 26'h0, r, d}, all_m);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid) begin
					s_axi_rready <= 1'b0;
					n = 99;
				end
			end
			if (n < 99) lost;
		end
	endtask
	task frame(input [7:0] t, input cb, input sb, input [7:0] code);
		begin
			@(posedge aclk);
			rx_fis_valid <= 1'b1;
			rx_fis_type <= t;
			rx_c_bit <= cb;
			rx_srst <= sb;
			rx_command <= code;
			@(posedge aclk);
			rx_fis_valid <= 1'b0;
		end
	endtask
	// back in idle once state_out reads idle four edges running
	task settle;
		integer n, k;
		begin
			k = 0;
			for (n = 0; n < 300 && k < 4; n = n + 1) begin
				@(posedge aclk);
				k = (state_out === 4'h0) ? k + 1 : 0;
			end
			if (k < 4) lost;
		end
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{rx_fis_valid, rx_c_bit, rx_srst, queued_ready, diag_pass, slow} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_fis_type, rx_command} = 72'h0;
		s_axi_wstrb = 4'hF;
		rnd = 32'hDBE3;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`SDCD_OFF_DEVREG, {16'h0, `SDCD_RST_DEV_ERROR, `SDCD_RST_DEV_STATUS}, `SDCD_RESP_OKAY);
		axr(`SDCD_OFF_REPLY, {16'h0, `SDCD_RST_ABORT_STATUS, `SDCD_RST_ABORT_ERROR}, `SDCD_RESP_OKAY);
		axr(12'h020, 32'h0, `SDCD_RESP_SLVERR);
		axw(12'h020, 32'h1, `SDCD_RESP_SLVERR);
		rnd = xs(rnd);
		op = rnd[7:0];
		note({4'h3, 8'h34, 4'h1, 8'h51, 8'h04, 32'h0}, hdr_m);
		frame(`SDCD_FIS_REG_H2D, 1'b1, 1'b0, op);
		settle;
		axr(`SDCD_OFF_COUNT, 32'h1, `SDCD_RESP_OKAY);
		frame(8'h39, 1'b1, 1'b0, op);
		settle;
		note(64'h5, all_m);
		frame(`SDCD_FIS_DMA_SETUP, 1'b0, 1'b0, op);
		settle;
		frame(`SDCD_FIS_REG_H2D, 1'b0, 1'b0, op);
		settle;
		for (c = 1; c <= 10; c = c + 1) begin
			op = c[7:0] * 8'h13;
			axw(`SDCD_OFF_CLASS_BASE + {2'h0, op, 2'h0}, c, `SDCD_RESP_OKAY);
			note({4'h1, 55'h0, c[4:0]}, all_m);
			frame(`SDCD_FIS_REG_H2D, 1'b1, 1'b0, op);
			settle;
		end
		rnd = xs(rnd);
		st = rnd[7:0];
		er = rnd[15:8];
		axw(`SDCD_OFF_DEVREG, {16'h0, er, st}, `SDCD_RESP_OKAY);
		note({4'h3, `SDCD_FIS_SDB, 4'h1, st | 8'h10, er, 32'h0}, hdr_m);
		@(posedge aclk);
		queued_ready <= 1'b1;
		@(posedge aclk);
		queued_ready <= 1'b0;
		settle;
		axw(`SDCD_OFF_CLASS_BASE + 12'h288, {27'h0, `SDCD_CLS_SERVICE}, `SDCD_RESP_OKAY);
		for (c = 0; c < 6; c = c + 1) begin
			rnd = xs(rnd);
			tg = rnd[4:0];
			slow <= rnd[8];
			axw(`SDCD_OFF_SERVICE, {21'h0, c[2:0], 3'h0, tg}, `SDCD_RESP_OKAY);
			if (c >= 2) note({4'h3, 8'h34, 4'h0, (st & 8'h7F) | 8'h08, er, tg, 27'h0}, 64'hFFFFFFFFFF000000);
			note({4'h1, 55'h0, 5'h0C + c[4:0]}, all_m);
			frame(`SDCD_FIS_REG_H2D, 1'b1, 1'b0, 8'hA2);
			settle;
		end
		for (c = 0; c < 2; c = c + 1) begin
			axw(`SDCD_OFF_CTRL, c, `SDCD_RESP_OKAY);
			diag_pass <= ~c[0];
			note(64'h6, all_m);
			frame(`SDCD_FIS_REG_H2D, 1'b0, 1'b1, 8'h00);
			repeat (6) @(posedge aclk);
			frame(`SDCD_FIS_REG_H2D, 1'b1, 1'b0, 8'h13);
			repeat (4) @(posedge aclk);
			frame(`SDCD_FIS_REG_H2D, 1'b0, 1'b1, 8'h00);
			repeat (4) @(posedge aclk);
			note({4'h3, `SDCD_FIS_REG_D2H, 4'h0, c[0] ? 8'h00 : `SDCD_DIAG_STATUS,
				c[0] ? `SDCD_DIAG_ERR_BAD : `SDCD_DIAG_ERR_GOOD, `SDCD_SIG_COUNT, `SDCD_SIG_SECTOR,
				c[0] ? `SDCD_SIG_PKT_HIGH : 8'h00, c[0] ? `SDCD_SIG_PKT_LOW : 8'h00}, all_m);
			frame(`SDCD_FIS_REG_H2D, 1'b0, 1'b0, 8'h00);
			settle;
		end
		if (exp_q.size() != 0) begin
			failures = failures + 1;
			$display("unexpected at %0t got %h exp %h", $time, 64'h0, exp_q[0]);
		end
		conclude;
	end
endmodule // sdcd_dispatch_tb
`default_nettype wire
